// ### core/bec_map.vh
// Constants for the bus event comparator
`ifndef BEC_MAP_VH
`define BEC_MAP_VH
// ==========================================
// Widths
`define BEC_AW 32
`define BEC_DW 32
`define BEC_SW 16
// ==========================================
// Register offsets (word index; byte address is four times this)
`define BEC_REG_CTRL 4'h0
`define BEC_REG_ADDR_START 4'h1
`define BEC_REG_ADDR_END 4'h2
`define BEC_REG_ADDR_MASK 4'h3
`define BEC_REG_DATA_START 4'h4
`define BEC_REG_DATA_END 4'h5
`define BEC_REG_DATA_MASK 4'h6
`define BEC_REG_SIG_CARE 4'h7
`define BEC_REG_SIG_LEVEL 4'h8
`define BEC_REG_STATUS 4'h9
`define BEC_REG_IRQ_MASK 4'ha
`define BEC_REG_MATCH_COUNT 4'hb
// ==========================================
// Control fields
`define BEC_CTRL_EN 0
`define BEC_CTRL_ADDR_EN 1
`define BEC_CTRL_ADDR_NOT 2
`define BEC_CTRL_ADDR_LEN 3
`define BEC_CTRL_DATA_EN 4
`define BEC_CTRL_DATA_NOT 5
`define BEC_CTRL_SPACE_EN 6
`define BEC_CTRL_SPACE_LO 8
`define BEC_CTRL_SPACE_HI 9
`define BEC_CTRL_RST 32'h0000_0000
`define BEC_AMASK_RST 32'hffff_ffff
`define BEC_DMASK_RST 32'hffff_ffff
// ==========================================
// Status fields
`define BEC_ST_LIVE 0
`define BEC_ST_TRACE 1
// ==========================================
// Address space selections
`define BEC_SPC_USER_DATA 2'h0
`define BEC_SPC_USER_PROG 2'h1
`define BEC_SPC_SUP_DATA 2'h2
`define BEC_SPC_SUP_PROG 2'h3
// Function code values of each space
`define BEC_FC_USER_DATA 3'h1
`define BEC_FC_USER_PROG 3'h2
`define BEC_FC_SUP_DATA 3'h5
`define BEC_FC_SUP_PROG 3'h6
`endif

// ### core/bec_comparator.v
// Bus event comparator: address, data, signal and space qualification
//
// How it works
// - Qualify address of every read or write
// - Start address is region's lowest address
// - Upper bound is end address or length
// - Mask zero ignores bit, one must match
// - Address invert matches outside range only
// - No address condition means always satisfied
// - Data compared against start and end range
// - Data mask ANDed; all ones exact match
// - Data invert matches outside range only
// - No data condition means always satisfied
// - Each signal required low, high or ignored
// - Event needs address, data, signals together
// - Optional restriction to one address space
// - Enabled match signals the trigger logic
// - Same definition evaluates recorded trace entries
// - Bus sampled and evaluated every clock
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "bec_map.vh"

module bec_comparator (
  input wire mclk,
  input wire rst,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire bus_valid,
  input wire [`BEC_AW-1:0] bus_addr,
  input wire [`BEC_DW-1:0] bus_data,
  input wire [`BEC_SW-1:0] bus_sig,
  input wire space_code_bit0,
  input wire space_code_bit1,
  input wire space_code_bit2,
  input wire trc_valid,
  input wire [`BEC_AW-1:0] trc_addr,
  input wire [`BEC_DW-1:0] trc_data,
  input wire [`BEC_SW-1:0] trc_sig,
  input wire [2:0] trc_space,
  output reg trig_event,
  output reg trc_hit,
  output wire irq
);

  // ==========================================
  // Registers
  reg [31:0] ctrl_q;
  reg [`BEC_AW-1:0] astart_q;
  reg [`BEC_AW-1:0] aend_q;
  reg [`BEC_AW-1:0] amask_q;
  reg [`BEC_DW-1:0] dstart_q;
  reg [`BEC_DW-1:0] dend_q;
  reg [`BEC_DW-1:0] dmask_q;
  reg [`BEC_SW-1:0] scare_q;
  reg [`BEC_SW-1:0] slevel_q;
  reg [1:0] status_q;
  reg [1:0] imask_q;
  reg [31:0] count_q;

  wire [`BEC_AW-1:0] ahi;
  wire live_match;
  wire trace_match;
  wire [`BEC_SW-1:0] live_sig_ok;
  wire [`BEC_SW-1:0] trace_sig_ok;
  wire [1:0] status_set;
  wire [1:0] status_clr;
  wire wr_ctrl;
  wire wr_astart;
  wire wr_aend;
  wire wr_amask;
  wire wr_dstart;
  wire wr_dend;
  wire wr_dmask;
  wire wr_scare;
  wire wr_slevel;
  wire wr_status;
  wire wr_imask;
  wire wr_count;

  // ==========================================
  // Register select, shared by every write decode
  function reg_sel;
    input [3:0] a;
    input [3:0] idx;
    begin
      reg_sel = (a == idx);
    end
  endfunction

  // ==========================================
  // Decoded write strobes
  assign wr_ctrl = reg_wr && reg_sel(reg_addr, `BEC_REG_CTRL);
  assign wr_astart = reg_wr && reg_sel(reg_addr, `BEC_REG_ADDR_START);
  assign wr_aend = reg_wr && reg_sel(reg_addr, `BEC_REG_ADDR_END);
  assign wr_amask = reg_wr && reg_sel(reg_addr, `BEC_REG_ADDR_MASK);
  assign wr_dstart = reg_wr && reg_sel(reg_addr, `BEC_REG_DATA_START);
  assign wr_dend = reg_wr && reg_sel(reg_addr, `BEC_REG_DATA_END);
  assign wr_dmask = reg_wr && reg_sel(reg_addr, `BEC_REG_DATA_MASK);
  assign wr_scare = reg_wr && reg_sel(reg_addr, `BEC_REG_SIG_CARE);
  assign wr_slevel = reg_wr && reg_sel(reg_addr, `BEC_REG_SIG_LEVEL);
  assign wr_status = reg_wr && reg_sel(reg_addr, `BEC_REG_STATUS);
  assign wr_imask = reg_wr && reg_sel(reg_addr, `BEC_REG_IRQ_MASK);
  assign wr_count = reg_wr && reg_sel(reg_addr, `BEC_REG_MATCH_COUNT);
  assign status_set = {trace_match, live_match};
  assign status_clr = wr_status ? reg_wdata[1:0] : 2'h0;

  // Upper bound from end address or from length
  assign ahi = ctrl_q[`BEC_CTRL_ADDR_LEN] ? (astart_q + aend_q - 32'h0000_0001)
                                         : aend_q;

  // ==========================================
  // Inclusive masked range test, shared by address and data
  function in_range;
    input [31:0] v;
    input [31:0] lo;
    input [31:0] hi;
    input [31:0] m;
    reg [31:0] vm;
    begin
      vm = v & m;
      in_range = (vm >= (lo & m)) && (vm <= (hi & m));
    end
  endfunction

  // ==========================================
  // Per-pin qualifier: checked pins must sit at their level
  function pin_ok;
    input care;
    input lvl;
    input pin;
    begin
      pin_ok = !care || (pin == lvl);
    end
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < `BEC_SW; gi = gi + 1) begin : g_pin
      assign live_sig_ok[gi] = pin_ok(scare_q[gi], slevel_q[gi], bus_sig[gi]);
      assign trace_sig_ok[gi] = pin_ok(scare_q[gi], slevel_q[gi], trc_sig[gi]);
    end
  endgenerate

  // ==========================================
  // Function code expected for the selected space
  function [2:0] space_code;
    input [1:0] sel;
    begin
      case (sel)
        `BEC_SPC_USER_DATA: space_code = `BEC_FC_USER_DATA;
        `BEC_SPC_USER_PROG: space_code = `BEC_FC_USER_PROG;
        `BEC_SPC_SUP_DATA: space_code = `BEC_FC_SUP_DATA;
        default: space_code = `BEC_FC_SUP_PROG;
      endcase
    end
  endfunction

  // ==========================================
  // Match function shared by live bus and trace entries
  function event_hit;
    input [31:0] c;
    input [`BEC_AW-1:0] a;
    input [`BEC_DW-1:0] d;
    input [`BEC_SW-1:0] s_ok;
    input [2:0] fc;
    input [`BEC_AW-1:0] a_lo;
    input [`BEC_AW-1:0] a_hi;
    input [`BEC_AW-1:0] a_m;
    input [`BEC_DW-1:0] d_lo;
    input [`BEC_DW-1:0] d_hi;
    input [`BEC_DW-1:0] d_m;
    reg a_ok;
    reg d_ok;
    reg sp_ok;
    begin
      a_ok = c[`BEC_CTRL_ADDR_EN] ? (in_range(a, a_lo, a_hi, a_m) ^ c[`BEC_CTRL_ADDR_NOT])
                                  : 1'b1;
      d_ok = c[`BEC_CTRL_DATA_EN] ? (in_range(d, d_lo, d_hi, d_m) ^ c[`BEC_CTRL_DATA_NOT])
                                  : 1'b1;
      sp_ok = c[`BEC_CTRL_SPACE_EN] ?
              (fc == space_code(c[`BEC_CTRL_SPACE_HI:`BEC_CTRL_SPACE_LO])) : 1'b1;
      event_hit = a_ok && d_ok && (&s_ok) && sp_ok;
    end
  endfunction

  assign live_match = ctrl_q[`BEC_CTRL_EN] && bus_valid &&
    event_hit(ctrl_q, bus_addr, bus_data, live_sig_ok,
              {space_code_bit2, space_code_bit1, space_code_bit0},
              astart_q, ahi, amask_q, dstart_q, dend_q, dmask_q);
  assign trace_match = trc_valid &&
    event_hit(ctrl_q, trc_addr, trc_data, trace_sig_ok, trc_space,
              astart_q, ahi, amask_q, dstart_q, dend_q, dmask_q);

  // ==========================================
  // Event outputs, evaluated each clock
  always @(posedge mclk) begin
    if (rst) begin
      trig_event <= 1'b0;
      trc_hit <= 1'b0;
    end else begin
      trig_event <= live_match;
      trc_hit <= trace_match;
    end
  end

  // ==========================================
  // Configuration registers, one process each
  always @(posedge mclk) begin
    if (rst) begin
      ctrl_q <= `BEC_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      astart_q <= 32'h0000_0000;
    end else if (wr_astart) begin
      astart_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      aend_q <= 32'h0000_0000;
    end else if (wr_aend) begin
      aend_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      amask_q <= `BEC_AMASK_RST;
    end else if (wr_amask) begin
      amask_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      dstart_q <= 32'h0000_0000;
    end else if (wr_dstart) begin
      dstart_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      dend_q <= 32'h0000_0000;
    end else if (wr_dend) begin
      dend_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      dmask_q <= `BEC_DMASK_RST;
    end else if (wr_dmask) begin
      dmask_q <= reg_wdata;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      scare_q <= 16'h0000;
    end else if (wr_scare) begin
      scare_q <= reg_wdata[15:0];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      slevel_q <= 16'h0000;
    end else if (wr_slevel) begin
      slevel_q <= reg_wdata[15:0];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      imask_q <= 2'h0;
    end else if (wr_imask) begin
      imask_q <= reg_wdata[1:0];
    end
  end

  // ==========================================
  // Sticky status: set wins over write-one-to-clear
  always @(posedge mclk) begin
    if (rst) begin
      status_q <= 2'h0;
    end else begin
      status_q <= (status_q & ~status_clr) | status_set;
    end
  end

  // Live match counter; a software write takes priority
  always @(posedge mclk) begin
    if (rst) begin
      count_q <= 32'h0000_0000;
    end else if (wr_count) begin
      count_q <= reg_wdata;
    end else if (live_match) begin
      count_q <= count_q + 32'h0000_0001;
    end
  end

  // ==========================================
  // Interrupt: any unmasked sticky bit
  assign irq = |(status_q & imask_q);

  // ==========================================
  // Read data, one cycle after strobe
  always @(posedge mclk) begin
    if (rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `BEC_REG_CTRL: reg_rdata <= ctrl_q;
        `BEC_REG_ADDR_START: reg_rdata <= astart_q;
        `BEC_REG_ADDR_END: reg_rdata <= aend_q;
        `BEC_REG_ADDR_MASK: reg_rdata <= amask_q;
        `BEC_REG_DATA_START: reg_rdata <= dstart_q;
        `BEC_REG_DATA_END: reg_rdata <= dend_q;
        `BEC_REG_DATA_MASK: reg_rdata <= dmask_q;
        `BEC_REG_SIG_CARE: reg_rdata <= {16'h0000, scare_q};
        `BEC_REG_SIG_LEVEL: reg_rdata <= {16'h0000, slevel_q};
        `BEC_REG_STATUS: reg_rdata <= {30'h0000_0000, status_q};
        `BEC_REG_IRQ_MASK: reg_rdata <= {30'h0000_0000, imask_q};
        `BEC_REG_MATCH_COUNT: reg_rdata <= count_q;
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // bec_comparator
`default_nettype wire

// ### testbench/bec_monitor.sv
// Port checker for the bus event comparator
`timescale 1ns/1ps
`default_nettype none
module bec_monitor (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic bus_valid,
  input wire logic trc_valid,
  input wire logic trig_event,
  input wire logic trc_hit,
  input wire logic irq
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================
  // Shadow of the enable bit
  logic en_q;
  always_ff @(posedge mclk)
    if (rst) en_q <= 1'b0;
    else if (reg_wr && reg_addr == 4'h0) en_q <= reg_wdata[0];
  // ==========================================
  // Assertions
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  live_cause_a: assert property (trig_event |-> $past(bus_valid))
    else $error("event without bus cycle");
  trace_cause_a: assert property (trc_hit |-> $past(trc_valid))
    else $error("hit without trace entry");
  enable_gate_a: assert property (trig_event |-> $past(en_q))
    else $error("event while disabled");
  quiet_off_a: assert property (!en_q [*2] |=> !trig_event)
    else $error("event after disable");
  irq_rise_a: assert property ($rose(irq) |-> trig_event || trc_hit || $past(reg_wr))
    else $error("irq rose without cause");
  irq_hold_a: assert property (irq && !reg_wr |=> irq)
    else $error("irq dropped without write");
  irq_fall_a: assert property ($fell(irq) |-> $past(reg_wr))
    else $error("irq fell without write");
  cover property (trig_event);
  cover property (trc_hit);
  cover property ($fell(irq));
endmodule // bec_monitor
bind bec_comparator bec_monitor i_mon (.mclk(mclk), .rst(rst), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_valid(bus_valid), .trc_valid(trc_valid), .trig_event(trig_event),
  .trc_hit(trc_hit), .irq(irq));
`default_nettype wire

// ### testbench/bec_cpu.sv
// Target processor bus model
`timescale 1ns/1ps
`default_nettype none
module bec_cpu (
  input wire logic mclk,
  output logic valid,
  output logic [31:0] addr,
  output logic [31:0] data,
  output logic [15:0] sig,
  output logic [2:0] fc
);
  initial {valid, addr, data, sig, fc} = '0;
  task cyc(input logic [31:0] a, d, input logic [15:0] s, input logic [2:0] f);
    @(posedge mclk);
    valid <= 1'b1;
    {addr, data, sig} <= {a, d, s};
    fc <= f;
    @(posedge mclk);
    valid <= 1'b0;
    {addr, data, sig, fc} <= ~{a, d, s, f};
  endtask
endmodule // bec_cpu
`default_nettype wire

// ### testbench/bec_comparator_bench.sv
// Self-checking bench for the bus event comparator
`timescale 1ns/1ps
`default_nettype none
module bec_comparator_bench;
  logic mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, trc_valid = 0;
  logic [3:0] reg_addr = 0;
  logic [31:0] reg_wdata = 0, reg_rdata, trc_addr = 0, trc_data = 0, ba, bd, hits = 0;
  logic [15:0] trc_sig = 0, bs;
  logic [2:0] trc_space = 0, fc;
  logic [2:0] fct [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
  logic bv, trig_event, trc_hit, irq;
  int err_count = 0, checks = 0;
  always #50 mclk = ~mclk;
  bec_cpu i_cpu (.mclk(mclk), .valid(bv), .addr(ba), .data(bd), .sig(bs), .fc(fc));
  bec_comparator i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_valid(bv), .bus_addr(ba),
    .bus_data(bd), .bus_sig(bs), .space_code_bit0(fc[0]), .space_code_bit1(fc[1]),
    .space_code_bit2(fc[2]), .trc_valid(trc_valid), .trc_addr(trc_addr),
    .trc_data(trc_data), .trc_sig(trc_sig), .trc_space(trc_space),
    .trig_event(trig_event), .trc_hit(trc_hit), .irq(irq));
  // ==========================================
  // Tasks
  task chk(input logic [31:0] g, e);
    checks++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge mclk);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, e);
  endtask
  task ev(input logic [31:0] a, d, input logic [15:0] s, input logic [2:0] f, input logic e);
    i_cpu.cyc(a, d, s, f);
    hits = hits + 32'(e);
    #1 chk(32'(trig_event), 32'(e));
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    err_count++;
    finish_test;
  end
  // ==========================================
  // Tests
  initial begin
    repeat (2) @(posedge mclk);
    rst <= 0;
    rd(4'h0, 32'h0);
    rd(4'h3, 32'hffffffff);
    rd(4'hf, 32'h0);
    wr(4'h1, 32'h100);
    wr(4'h2, 32'h1ff);
    wr(4'h4, 32'h10);
    wr(4'h5, 32'h20);
    wr(4'h7, 32'h1);
    wr(4'h8, 32'h1);
    wr(4'h0, 32'h13);
    ev(32'h100, 32'h10, 16'h1, 3'h1, 1);
    ev(32'h1ff, 32'h20, 16'h3, 3'h1, 1);
    ev(32'h200, 32'h10, 16'h1, 3'h1, 0);
    ev(32'hff, 32'h10, 16'h1, 3'h1, 0);
    ev(32'h150, 32'h21, 16'h1, 3'h1, 0);
    ev(32'h150, 32'h15, 16'h0, 3'h1, 0);
    wr(4'h0, 32'h37);
    ev(32'h200, 32'h30, 16'h1, 3'h1, 1);
    ev(32'h150, 32'h30, 16'h1, 3'h1, 0);
    ev(32'h200, 32'h15, 16'h1, 3'h1, 0);
    $display("range test done");
    wr(4'h2, 32'h10);
    wr(4'h0, 32'h1b);
    ev(32'h10f, 32'h10, 16'h1, 3'h1, 1);
    ev(32'h110, 32'h10, 16'h1, 3'h1, 0);
    wr(4'h3, 32'hfff);
    ev(32'h70000105, 32'h10, 16'h1, 3'h1, 1);
    wr(4'h6, 32'hf);
    ev(32'h105, 32'hf0, 16'h1, 3'h1, 1);
    ev(32'h105, 32'h13, 16'h1, 3'h1, 0);
    $display("mask test done");
    for (int i = 0; i < 4; i++) begin
      wr(4'h0, 32'h41 | (i << 8));
      ev(32'h0, 32'hffff, 16'h1, fct[i], 1);
      ev(32'h0, 32'hffff, 16'h1, fct[(i + 1) % 4], 0);
    end
    wr(4'h0, 32'h0);
    ev(32'h0, 32'h0, 16'h1, 3'h1, 0);
    rd(4'hb, hits);
    wr(4'ha, 32'h0);
    wr(4'h9, 32'h3);
    @(posedge mclk);
    {trc_valid, trc_sig} <= {1'b1, 16'h1};
    @(posedge mclk);
    trc_valid <= 1'b0;
    #1 chk(32'(trc_hit), 32'h1);
    rd(4'h9, 32'h2);
    chk(32'(irq), 32'h0);
    wr(4'ha, 32'h2);
    #1 chk(32'(irq), 32'h1);
    wr(4'h9, 32'h2);
    #1 chk(32'(irq), 32'h0);
    $display("event test done");
    finish_test;
  end
endmodule // bec_comparator_bench
`default_nettype wire
